//--- design/pcpwm_compare_unit.sv
// One compare unit: buffered compare value, match detect and waveform output
`timescale 1ns/1ps
module pcpwm_compare_unit #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_buf,
    input wire logic [WIDTH-1:0] wr_value,
    input wire logic load_active,
    input wire logic tick,
    input wire logic counting_up,
    input wire logic [WIDTH-1:0] counter_value,
    input wire logic [WIDTH-1:0] top_value,
    input wire logic [1:0] compare_output_mode,
    output logic [WIDTH-1:0] buffer_value,
    output logic [WIDTH-1:0] active_value,
    output logic match_pulse,
    output logic waveform_output
);
    logic [WIDTH-1:0] buf_q;
    logic [WIDTH-1:0] act_q;
    logic wave_q;
    logic wave_d;
    wire active_mode = compare_output_mode[1];
    // A value above top can never be reached, so it never matches
    wire match = tick && (counter_value == act_q) && (act_q <= top_value);
    assign buffer_value = buf_q;
    assign active_value = act_q;
    assign match_pulse = match;
    assign waveform_output = wave_q;

    // Non-inverted clears upward and sets downward; inverted swaps them
    always_comb
    begin
        wave_d = wave_q;
        if (match && active_mode)
        begin
            if (compare_output_mode == pcpwm_pkg::OUT_NONINV)
                wave_d = !counting_up;
            else if (compare_output_mode == pcpwm_pkg::OUT_INV)
                wave_d = counting_up;
        end
        else if (!active_mode)
            wave_d = 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            buf_q <= pcpwm_pkg::CMP_RESET;
            act_q <= pcpwm_pkg::CMP_RESET;
            wave_q <= 1'b0;
        end
        else
        begin
            if (wr_buf)
                buf_q <= wr_value;
            if (load_active)
                act_q <= wr_buf ? wr_value : buf_q;
            wave_q <= wave_d;
        end
    end
endmodule : pcpwm_compare_unit

//--- design/pcpwm_pkg.sv
// Constants for the phase-correct PWM timer: register map, fields, reset values
package pcpwm_pkg;
    localparam int CNT_W = 16;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TOP_SEL = 4'h1;
    localparam logic [3:0] ADDR_CMP_A = 4'h2;
    localparam logic [3:0] ADDR_CMP_B = 4'h3;
    localparam logic [3:0] ADDR_CAPTURE = 4'h4;
    localparam logic [3:0] ADDR_COUNTER = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_MASK = 4'h7;
    localparam logic [3:0] ADDR_PRESCALE = 4'h8;
    // Control fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MODE_A_LSB = 1;
    localparam int CTRL_MODE_B_LSB = 3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Top source select codes
    localparam logic [2:0] TOP_FIX8 = 3'h0;
    localparam logic [2:0] TOP_FIX9 = 3'h1;
    localparam logic [2:0] TOP_FIX10 = 3'h2;
    localparam logic [2:0] TOP_CAPTURE = 3'h3;
    localparam logic [2:0] TOP_CMP_A = 3'h4;
    localparam logic [15:0] TOP_VAL_8 = 16'h00FF;
    localparam logic [15:0] TOP_VAL_9 = 16'h01FF;
    localparam logic [15:0] TOP_VAL_10 = 16'h03FF;
    localparam logic [2:0] TOP_SEL_RESET = 3'h0;
    // Status and mask bit positions
    localparam int ST_OVF = 0;
    localparam int ST_MATCH_A = 1;
    localparam int ST_MATCH_B = 2;
    localparam int ST_CAPTURE = 3;
    localparam int ST_TOP = 4;
    localparam int ST_W = 5;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [15:0] PRESCALE_RESET = 16'h0000;
    // Output mode codes
    localparam logic [1:0] OUT_NONINV = 2'h2;
    localparam logic [1:0] OUT_INV = 2'h3;
    typedef enum logic {PCPWM_UP, PCPWM_DOWN} pcpwm_dir_t;
endpackage : pcpwm_pkg

//--- design/pcpwm_timer.sv
// Phase-correct PWM 16-bit timer with two compare units and register port
`timescale 1ns/1ps
module pcpwm_timer #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq,
    output logic waveform_output_a,
    output logic waveform_output_b
);
    logic [15:0] ctrl_q;
    logic [2:0] top_sel_q;
    logic [15:0] prescale_q;
    logic [15:0] presc_cnt_q;
    logic [WIDTH-1:0] counter_value_q;
    logic [WIDTH-1:0] counter_value_d;
    logic [WIDTH-1:0] capture_value_q;
    pcpwm_pkg::pcpwm_dir_t dir_q;
    pcpwm_pkg::pcpwm_dir_t dir_d;
    logic [pcpwm_pkg::ST_W-1:0] status_q;
    logic [pcpwm_pkg::ST_W-1:0] mask_q;
    logic [15:0] rdata_q;
    logic [WIDTH-1:0] top_value;
    logic [WIDTH-1:0] fixed_mask;
    logic [WIDTH-1:0] buf_a;
    logic [WIDTH-1:0] buf_b;
    logic [WIDTH-1:0] act_a;
    logic [WIDTH-1:0] act_b;
    logic match_a;
    logic match_b;
    logic [15:0] rd_mux;

    function automatic logic [WIDTH-1:0] fit(input logic [15:0] v);
        fit = WIDTH'(v);
    endfunction : fit

    wire run = ctrl_q[pcpwm_pkg::CTRL_RUN_BIT];
    wire [1:0] mode_a = ctrl_q[pcpwm_pkg::CTRL_MODE_A_LSB +: 2];
    wire [1:0] mode_b = ctrl_q[pcpwm_pkg::CTRL_MODE_B_LSB +: 2];
    wire fixed_top = (top_sel_q == pcpwm_pkg::TOP_FIX8) || (top_sel_q == pcpwm_pkg::TOP_FIX9)
        || (top_sel_q == pcpwm_pkg::TOP_FIX10);
    wire top_is_capture = (top_sel_q == pcpwm_pkg::TOP_CAPTURE);
    wire top_is_cmp_a = (top_sel_q == pcpwm_pkg::TOP_CMP_A);

    // Timer tick from the prescaler: one system clock in (prescale+1)
    wire tick = run && (presc_cnt_q == prescale_q);

    // Fixed tops define their resolution; the mask doubles as the top value
    always_comb
    begin
        fixed_mask = {WIDTH{1'b1}};
        unique case (top_sel_q)
            pcpwm_pkg::TOP_FIX8: fixed_mask = fit(pcpwm_pkg::TOP_VAL_8);
            pcpwm_pkg::TOP_FIX9: fixed_mask = fit(pcpwm_pkg::TOP_VAL_9);
            pcpwm_pkg::TOP_FIX10: fixed_mask = fit(pcpwm_pkg::TOP_VAL_10);
            pcpwm_pkg::TOP_CAPTURE: fixed_mask = {WIDTH{1'b1}};
            pcpwm_pkg::TOP_CMP_A: fixed_mask = {WIDTH{1'b1}};
            default: fixed_mask = {WIDTH{1'b1}};
        endcase
    end

    // Compare A as top uses its active copy, so the slope keeps the old top
    assign top_value = fixed_top ? fixed_mask : (top_is_capture ? capture_value_q : act_a);

    wire at_top = tick && (counter_value_q == top_value) && (dir_q == pcpwm_pkg::PCPWM_UP);
    wire at_bottom = tick && (counter_value_q == {{(WIDTH-1){1'b0}}, 1'b1})
        && (dir_q == pcpwm_pkg::PCPWM_DOWN);

    // Up to top then down to bottom, turning at each end
    always_comb
    begin
        counter_value_d = counter_value_q;
        dir_d = dir_q;
        if (tick)
        begin
            if (dir_q == pcpwm_pkg::PCPWM_UP)
            begin
                if (counter_value_q >= top_value)
                begin
                    dir_d = pcpwm_pkg::PCPWM_DOWN;
                    counter_value_d = (counter_value_q == {WIDTH{1'b0}}) ? counter_value_q
                        : counter_value_q - 1'b1;
                end
                else
                    counter_value_d = counter_value_q + 1'b1;
            end
            else if (counter_value_q == {WIDTH{1'b0}})
            begin
                // Count at bottom while falling (software write, or a top of zero): turn instead of wrapping to all ones
                dir_d = pcpwm_pkg::PCPWM_UP;
                counter_value_d = counter_value_q + 1'b1;
            end
            else
            begin
                counter_value_d = counter_value_q - 1'b1;
                if (counter_value_q == {{(WIDTH-1){1'b0}}, 1'b1})
                    dir_d = pcpwm_pkg::PCPWM_UP;
            end
        end
    end

    // Writes to compare registers lose the bits above a fixed resolution
    wire [WIDTH-1:0] cmp_wdata = fit(reg_wdata) & (fixed_top ? fixed_mask : {WIDTH{1'b1}});
    wire wr_a = reg_wr && (reg_addr == pcpwm_pkg::ADDR_CMP_A);
    wire wr_b = reg_wr && (reg_addr == pcpwm_pkg::ADDR_CMP_B);
    wire wr_cnt = reg_wr && (reg_addr == pcpwm_pkg::ADDR_COUNTER);
    wire wr_status = reg_wr && (reg_addr == pcpwm_pkg::ADDR_STATUS);

    // Event vector in status layout
    wire [pcpwm_pkg::ST_W-1:0] events = {
        at_top,
        at_top && top_is_capture,
        match_b || (at_top && top_is_cmp_a && 1'b0),
        match_a || (at_top && top_is_cmp_a),
        at_bottom
    };

    pcpwm_compare_unit #(.WIDTH(WIDTH)) u_cmp_a (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_buf(wr_a),
        .wr_value(cmp_wdata),
        .load_active(at_top),
        .tick(tick),
        .counting_up(dir_q == pcpwm_pkg::PCPWM_UP),
        .counter_value(counter_value_q),
        .top_value(top_value),
        .compare_output_mode(mode_a),
        .buffer_value(buf_a),
        .active_value(act_a),
        .match_pulse(match_a),
        .waveform_output(waveform_output_a)
    );

    pcpwm_compare_unit #(.WIDTH(WIDTH)) u_cmp_b (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_buf(wr_b),
        .wr_value(cmp_wdata),
        .load_active(at_top),
        .tick(tick),
        .counting_up(dir_q == pcpwm_pkg::PCPWM_UP),
        .counter_value(counter_value_q),
        .top_value(top_value),
        .compare_output_mode(mode_b),
        .buffer_value(buf_b),
        .active_value(act_b),
        .match_pulse(match_b),
        .waveform_output(waveform_output_b)
    );

    always_comb
    begin
        rd_mux = 16'h0000;
        unique case (reg_addr)
            pcpwm_pkg::ADDR_CTRL: rd_mux = ctrl_q;
            pcpwm_pkg::ADDR_TOP_SEL: rd_mux = {13'h0000, top_sel_q};
            pcpwm_pkg::ADDR_CMP_A: rd_mux = 16'(buf_a);
            pcpwm_pkg::ADDR_CMP_B: rd_mux = 16'(buf_b);
            pcpwm_pkg::ADDR_CAPTURE: rd_mux = 16'(capture_value_q);
            pcpwm_pkg::ADDR_COUNTER: rd_mux = 16'(counter_value_q);
            pcpwm_pkg::ADDR_STATUS: rd_mux = {11'h000, status_q};
            pcpwm_pkg::ADDR_MASK: rd_mux = {11'h000, mask_q};
            pcpwm_pkg::ADDR_PRESCALE: rd_mux = prescale_q;
            default: rd_mux = 16'h0000;
        endcase
    end

    assign reg_rdata = rdata_q;
    assign irq = |(status_q & mask_q);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ctrl_q <= pcpwm_pkg::CTRL_RESET;
            top_sel_q <= pcpwm_pkg::TOP_SEL_RESET;
            capture_value_q <= fit(pcpwm_pkg::CAPTURE_RESET);
            prescale_q <= pcpwm_pkg::PRESCALE_RESET;
            mask_q <= '0;
            rdata_q <= 16'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == pcpwm_pkg::ADDR_CTRL)
                ctrl_q <= reg_wdata;
            if (reg_wr && reg_addr == pcpwm_pkg::ADDR_TOP_SEL)
                top_sel_q <= reg_wdata[2:0];
            if (reg_wr && reg_addr == pcpwm_pkg::ADDR_CAPTURE)
                capture_value_q <= fit(reg_wdata);
            if (reg_wr && reg_addr == pcpwm_pkg::ADDR_PRESCALE)
                prescale_q <= reg_wdata;
            if (reg_wr && reg_addr == pcpwm_pkg::ADDR_MASK)
                mask_q <= reg_wdata[pcpwm_pkg::ST_W-1:0];
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // Set beats a write-one clear arriving in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            status_q <= '0;
        else
            status_q <= (status_q & ~(wr_status ? reg_wdata[pcpwm_pkg::ST_W-1:0] : '0)) | events;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            presc_cnt_q <= 16'h0000;
            counter_value_q <= '0;
            dir_q <= pcpwm_pkg::PCPWM_UP;
        end
        else
        begin
            presc_cnt_q <= (!run || tick) ? 16'h0000 : presc_cnt_q + 16'h0001;
            counter_value_q <= wr_cnt ? fit(reg_wdata) : counter_value_d;
            dir_q <= dir_d;
        end
    end
endmodule : pcpwm_timer

//--- test/pcpwm_checker.sv
// Port-level assertions for the phase-correct PWM timer
`timescale 1ns/1ps
module pcpwm_checker #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic irq,
    input wire logic waveform_output_a,
    input wire logic waveform_output_b
);
    logic [2:0] top_sel_q;
    logic [1:0] mode_a_q;
    logic [1:0] mode_b_q;
    logic run_q;
    logic [2:0] quiet_q;
    wire ctrl_wr = reg_wr && reg_addr == pcpwm_pkg::ADDR_CTRL;
    // Quiet counts idle cycles with the timer stopped, saturating at 7
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            top_sel_q <= pcpwm_pkg::TOP_SEL_RESET;
            mode_a_q <= 2'h0;
            mode_b_q <= 2'h0;
            run_q <= 1'b0;
            quiet_q <= 3'h0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                run_q <= reg_wdata[pcpwm_pkg::CTRL_RUN_BIT];
                mode_a_q <= reg_wdata[2:1];
                mode_b_q <= reg_wdata[4:3];
            end
            if (reg_wr && reg_addr == pcpwm_pkg::ADDR_TOP_SEL)
                top_sel_q <= reg_wdata[2:0];
            quiet_q <= (run_q || reg_wr) ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    sequence s_mask_wr;
        reg_wr && reg_addr == pcpwm_pkg::ADDR_MASK;
    endsequence
    sequence s_mask_rd;
        reg_rd && reg_addr == pcpwm_pkg::ADDR_MASK;
    endsequence
    sequence s_cmpa_wr_fix8;
        reg_wr && reg_addr == pcpwm_pkg::ADDR_CMP_A && top_sel_q == pcpwm_pkg::TOP_FIX8;
    endsequence
    sequence s_cmpa_rd;
        reg_rd && reg_addr == pcpwm_pkg::ADDR_CMP_A;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_unmapped_zero: assert property (reg_rd && reg_addr > pcpwm_pkg::ADDR_PRESCALE |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_mask_readback: assert property (s_mask_wr ##1 s_mask_rd |=> reg_rdata == {11'h000, $past(reg_wdata[4:0], 2)})
        else $error("mask readback wrong");
    a_fix8_masking: assert property (s_cmpa_wr_fix8 ##1 s_cmpa_rd |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)})
        else $error("compare bits above fixed top not cleared");
    a_irq_masked: assert property (reg_wr && reg_addr == pcpwm_pkg::ADDR_MASK && reg_wdata[4:0] == 5'h00 |=> !irq)
        else $error("interrupt high with all sources masked");
    a_wave_off_a: assert property (mode_a_q < 2'h2 && $past(mode_a_q) < 2'h2 |-> !waveform_output_a)
        else $error("output A active with PWM mode off");
    a_wave_off_b: assert property (mode_b_q < 2'h2 && $past(mode_b_q) < 2'h2 |-> !waveform_output_b)
        else $error("output B active with PWM mode off");
    a_stopped_hold: assert property (quiet_q == 3'h7 |-> $stable(waveform_output_a) && $stable(waveform_output_b) && $stable(irq))
        else $error("outputs moved while timer stopped");
endmodule : pcpwm_checker

bind pcpwm_timer pcpwm_checker #(.WIDTH(WIDTH)) chk_u (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .waveform_output_a(waveform_output_a), .waveform_output_b(waveform_output_b));

//--- test/tb_top.sv
// Self-checking bench for the phase-correct PWM timer
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin mismatches++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top;
    localparam logic [15:0] TOPV = pcpwm_pkg::TOP_VAL_8;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic irq;
    logic wave_a;
    logic wave_b;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 32'hc46b;
    int cycles = 0;
    logic [15:0] v, p, c0, c1;
    logic lv;
    logic up;
    int w;
    always #10 sys_clk = ~sys_clk;
    pcpwm_timer #(.WIDTH(16)) dut_u (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .waveform_output_a(wave_a),
        .waveform_output_b(wave_b));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            finish_test();
        end
    end
    function automatic logic [15:0] fix_top(input int s);
        return (s == 0) ? pcpwm_pkg::TOP_VAL_8 : ((s == 1) ? pcpwm_pkg::TOP_VAL_9 : pcpwm_pkg::TOP_VAL_10);
    endfunction : fix_top
    // Width of the level that spans top when the compare value moves from a to b at top
    function automatic int pw(input logic [15:0] a, input logic [15:0] b);
        return 2 * TOPV - a - b;
    endfunction : pw
    task automatic bus(input logic wt, input logic rt, input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= wt;
        reg_rd <= rt;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        bus(1'b0, 1'b1, a, 16'h0000);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        q = reg_rdata;
    endtask : rd
    task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        bus(1'b1, 1'b0, a, d);
        rd(a, q);
    endtask : wr_rd
    // Waits for level l on output A, then counts the cycles it lasts
    task automatic span(input logic l, output int n);
        n = 0;
        while (wave_a !== l && n < 2000)
        begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        while (wave_a === l && n < 2000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask : span
    // Runs the timer, clears early flags, then checks flags raised later
    task automatic run_flags(input logic [15:0] m, input logic [15:0] e);
        wr(pcpwm_pkg::ADDR_COUNTER, 16'h0000);
        wr(pcpwm_pkg::ADDR_CTRL, 16'h0015);
        repeat (300) @(posedge sys_clk);
        wr(pcpwm_pkg::ADDR_STATUS, 16'h001F);
        repeat (300) @(posedge sys_clk);
        rd(pcpwm_pkg::ADDR_STATUS, v);
        `CHK("run flags", e, v & m)
        wr(pcpwm_pkg::ADDR_CTRL, 16'h0000);
    endtask : run_flags
    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        for (int a = 0; a < 16; a++)
        begin
            rd(a[3:0], v);
            `CHK("reset value", 16'h0000, v)
        end
        v = 16'($random(seed));
        wr_rd(pcpwm_pkg::ADDR_MASK, v, p);
        `CHK("mask", v & 16'h001F, p)
        c1 = 16'h0040;
        wr(pcpwm_pkg::ADDR_CMP_A, c1);
        wr(pcpwm_pkg::ADDR_MASK, 16'h0000);
        wr(pcpwm_pkg::ADDR_CTRL, 16'h0015);
        bus(1'b0, 1'b1, pcpwm_pkg::ADDR_COUNTER, 16'h0000);
        up = 1'b1;
        @(negedge sys_clk);
        for (int n = 0; n < 600; n++)
        begin
            @(negedge sys_clk);
            p = v;
            v = reg_rdata;
            if (n > 0)
                `CHK("counter", up ? p + 16'h0001 : p - 16'h0001, v)
            if (v == TOPV)
                up = 1'b0;
            if (v == 16'h0000)
                up = 1'b1;
        end
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        rd(pcpwm_pkg::ADDR_STATUS, v);
        `CHK("status flags", 16'h0013, v & 16'h0013)
        wr(pcpwm_pkg::ADDR_MASK, 16'h0010);
        @(negedge sys_clk);
        `CHK("irq set", 1'b1, irq)
        wr(pcpwm_pkg::ADDR_MASK, 16'h0000);
        @(negedge sys_clk);
        `CHK("irq masked", 1'b0, irq)
        $display("test count done");
        // Odd passes use the inverted mode; compare rewritten just after a down match
        for (int i = 0; i < 6; i++)
        begin
            lv = i[0];
            c0 = c1;
            c1 = 16'h0010 + (16'($random(seed)) & 16'h00DF);
            wr(pcpwm_pkg::ADDR_CTRL, lv ? 16'h001F : 16'h0015);
            span(lv, w);
            wr(pcpwm_pkg::ADDR_CMP_A, c1);
            span(lv, w);
            `CHK("first width", pw(c0, c1), w)
            span(lv, w);
            `CHK("steady width", pw(c1, c1), w)
        end
        $display("test waveform done");
        wr(pcpwm_pkg::ADDR_CTRL, 16'h0000);
        wr(pcpwm_pkg::ADDR_STATUS, 16'h001F);
        rd(pcpwm_pkg::ADDR_STATUS, v);
        `CHK("status clear", 16'h0000, v)
        // Top source and capture value are written only while the timer is stopped
        wr(pcpwm_pkg::ADDR_TOP_SEL, {13'h0000, pcpwm_pkg::TOP_CAPTURE});
        wr(pcpwm_pkg::ADDR_CAPTURE, 16'h0080);
        wr(pcpwm_pkg::ADDR_CMP_A, 16'h00C0);
        run_flags(16'h000B, 16'h0009);
        // New top from compare A is never below compare B (zero)
        wr(pcpwm_pkg::ADDR_TOP_SEL, {13'h0000, pcpwm_pkg::TOP_CMP_A});
        wr(pcpwm_pkg::ADDR_CMP_A, 16'h0060);
        run_flags(16'h0012, 16'h0012);
        $display("test flags done");
        for (int s = 0; s < 3; s++)
        begin
            wr(pcpwm_pkg::ADDR_TOP_SEL, 16'(s));
            v = 16'($random(seed));
            wr_rd(pcpwm_pkg::ADDR_CMP_A, v, p);
            `CHK("masked compare", v & fix_top(s), p)
        end
        $display("test masking done");
        finish_test();
    end
endmodule : tb_top
